/* File: hdl/usb_bus_state_pkg.sv */
// constants, types and helpers of the usb bus state event logic
// Operation
// - while suspended, any non-idle line state sets the resume flag, bit 7.
// - single-ended zero held 2.5 us sets the bus reset flag, bit 6.
// - 3 ms of continuous idle sets the short suspend flag, bit 4.
// - 5 ms of continuous idle sets the long suspend flag, bit 5; wake allowed.
// - every valid end of packet sets the packet end flag, bit 3.
// - after remote wake-up, the packet end flag marks resume completion by host.
// - reading the bus state event register clears its flags; reserved bits zero.
// - bus state enable bits 7..3 let matching flags set the summary bit.
// - main enable bits 4..0 enable nak, frame, transmit, bus state, warning.
// - summary bit shows any enabled flag set; clears when flags are read.
// - a main event interrupts only if its enable and master bit 7 are one.
package usb_bus_state_pkg;
   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;
   // register indices; byte address is four times the low ten bits of the index
   localparam logic [31:0] MAIN_EVENT_INDEX = 32'h5000180C;
   localparam logic [31:0] MAIN_EVENT_ENABLE_INDEX = 32'h5000180E;
   localparam logic [31:0] BUS_STATE_EVENTS_INDEX = 32'h50001810;
   localparam logic [31:0] BUS_STATE_EVENT_ENABLE_INDEX = 32'h50001812;
   // interrupt registers, byte addresses
   localparam logic [11:0] IRQ_STATUS_ADDR = 12'h060;
   localparam logic [11:0] IRQ_CLEAR_ADDR = 12'h064;
   localparam logic [11:0] IRQ_ENABLE_ADDR = 12'h068;
   // bus state event field: bits 7..3 held as a 5-bit vector
   localparam int BUS_EVENT_LSB = 3;
   localparam int BUS_EVENT_W = 5;
   localparam int RESUME_BIT = 4;
   localparam int RESET_BIT = 3;
   localparam int LONG_SUSPEND_BIT = 2;
   localparam int SHORT_SUSPEND_BIT = 1;
   localparam int PACKET_END_BIT = 0;
   // main event and main enable fields
   localparam int MAIN_ENABLE_W = 12;
   localparam int MASTER_ENABLE_BIT = 7;
   localparam int MAIN_SOURCE_W = 5;
   localparam int NAK_BIT = 4;
   localparam int FRAME_BIT = 3;
   localparam int TRANSMIT_BIT = 2;
   localparam int SUMMARY_BIT = 1;
   localparam int WARNING_BIT = 0;
   // reset values
   localparam logic [MAIN_ENABLE_W-1:0] MAIN_EVENT_ENABLE_RESET = 12'h000;
   localparam logic [BUS_EVENT_W-1:0] BUS_STATE_EVENTS_RESET = 5'h00;
   localparam logic [BUS_EVENT_W-1:0] BUS_STATE_ENABLE_RESET = 5'h00;
   localparam logic [BUS_EVENT_W-1:0] IRQ_ENABLE_RESET = 5'h00;
   // timing
   localparam int CLK_PERIOD_NS = 50;
   localparam int SE0_RESET_NS = 2500;
   localparam int SE0_RESET_CYCLES = (SE0_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SHORT_SUSPEND_MS = 3;
   localparam int LONG_SUSPEND_MS = 5;
   localparam int SHORT_SUSPEND_CYCLES = SHORT_SUSPEND_MS * 1000000 / CLK_PERIOD_NS;
   localparam int LONG_SUSPEND_CYCLES = LONG_SUSPEND_MS * 1000000 / CLK_PERIOD_NS;
   localparam int SE0_CNT_W = 7;
   localparam int IDLE_CNT_W = 17;

   typedef enum logic [1:0] {node_reset, node_resume, node_operational, node_suspend} node_state_e;

   // byte address of a register index
   function automatic logic [ADDR_W-1:0] reg_addr(input logic [31:0] index);
      reg_addr = {index[ADDR_W-3:0], 2'b00};
   endfunction

   // byte-lane merge of a 16-bit register write
   function automatic logic [15:0] lane_merge(input logic [15:0] old_value,
                                              input logic [15:0] wdata,
                                              input logic [1:0] strb);
      lane_merge = {strb[1] ? wdata[15:8] : old_value[15:8],
                    strb[0] ? wdata[7:0] : old_value[7:0]};
   endfunction
endpackage

/* File: hdl/line_event_if.sv */
// line events passed from the line monitor to the register core
`timescale 1ns/10ps
interface line_event_if;
   logic se0_reset;
   logic short_idle;
   logic long_idle;
   logic packet_end;
   logic non_idle;
   modport monitor (output se0_reset, output short_idle, output long_idle,
                    output packet_end, output non_idle);
   modport core (input se0_reset, input short_idle, input long_idle,
                 input packet_end, input non_idle);
endinterface

/* File: hdl/line_monitor.sv */
// synchronises the usb line pins and times reset, idle and end of packet
`timescale 1ns/10ps
module line_monitor
   import usb_bus_state_pkg::*;
#(
   parameter int SHORT_CYCLES = SHORT_SUSPEND_CYCLES,
   parameter int LONG_CYCLES = LONG_SUSPEND_CYCLES
) (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic dp_pin,
   input wire logic dm_pin,
   line_event_if.monitor ev
);
   typedef struct packed {
      logic dp_meta;
      logic dm_meta;
      logic dp_sync;
      logic dm_sync;
      logic [SE0_CNT_W-1:0] se0_count;
      logic [IDLE_CNT_W-1:0] idle_count;
      logic se0_reset;
      logic short_idle;
      logic long_idle;
      logic packet_end;
      logic non_idle;
   } monitor_s;

   monitor_s st;
   monitor_s next_st;
   logic line_j;
   logic line_se0;

   always_comb begin
      next_st = st;
      next_st.dp_meta = dp_pin;
      next_st.dm_meta = dm_pin;
      next_st.dp_sync = st.dp_meta;
      next_st.dm_sync = st.dm_meta;
      line_j = st.dp_sync & ~st.dm_sync;
      line_se0 = ~st.dp_sync & ~st.dm_sync;
      next_st.se0_reset = 1'b0;
      next_st.short_idle = 1'b0;
      next_st.long_idle = 1'b0;
      next_st.packet_end = 1'b0;
      next_st.non_idle = ~line_j;
      if (line_se0) begin
         if (st.se0_count != SE0_CNT_W'(SE0_RESET_CYCLES)) begin
            next_st.se0_count = st.se0_count + 1'b1;
         end
         next_st.se0_reset = (st.se0_count == SE0_CNT_W'(SE0_RESET_CYCLES - 1));
      end else begin
         next_st.se0_count = '0;
         // short single-ended zero followed by idle is a valid end of packet
         next_st.packet_end = line_j && (st.se0_count != '0)
                              && (st.se0_count < SE0_CNT_W'(SE0_RESET_CYCLES));
      end
      if (line_j) begin
         if (st.idle_count != IDLE_CNT_W'(LONG_CYCLES)) begin
            next_st.idle_count = st.idle_count + 1'b1;
         end
         next_st.short_idle = (st.idle_count == IDLE_CNT_W'(SHORT_CYCLES - 1));
         next_st.long_idle = (st.idle_count == IDLE_CNT_W'(LONG_CYCLES - 1));
      end else begin
         next_st.idle_count = '0;
      end
   end

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         // sync flops start at the idle j level, so release shows no false packet end
         st <= '0;
         st.dp_meta <= 1'b1;
         st.dp_sync <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   assign ev.se0_reset = st.se0_reset;
   assign ev.short_idle = st.short_idle;
   assign ev.long_idle = st.long_idle;
   assign ev.packet_end = st.packet_end;
   assign ev.non_idle = st.non_idle;
endmodule

/* File: hdl/irq_bank.sv */
// sticky interrupt status with enable and write-one-to-clear
`timescale 1ns/10ps
module irq_bank
   import usb_bus_state_pkg::*;
(
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic [BUS_EVENT_W-1:0] event_set,
   input wire logic clear_we,
   input wire logic [BUS_EVENT_W-1:0] clear_bits,
   input wire logic enable_we,
   input wire logic [BUS_EVENT_W-1:0] enable_bits,
   output logic [BUS_EVENT_W-1:0] status,
   output logic [BUS_EVENT_W-1:0] enable,
   output logic irq
);
   typedef struct packed {
      logic [BUS_EVENT_W-1:0] status;
      logic [BUS_EVENT_W-1:0] enable;
      logic irq;
   } irq_s;

   irq_s st;
   irq_s next_st;

   always_comb begin
      next_st = st;
      if (clear_we) begin
         next_st.status = st.status & ~clear_bits;
      end
      next_st.status = next_st.status | event_set;
      if (enable_we) begin
         next_st.enable = enable_bits;
      end
      next_st.irq = |(next_st.status & next_st.enable);
   end

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         st <= {BUS_STATE_EVENTS_RESET, IRQ_ENABLE_RESET, 1'b0};
      end else begin
         st <= next_st;
      end
   end

   assign status = st.status;
   assign enable = st.enable;
   assign irq = st.irq;
endmodule

/* File: hdl/usb_bus_state_events.sv */
// usb bus state event, mask and main interrupt logic with apb register port
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/10ps
module usb_bus_state_events
   import usb_bus_state_pkg::*;
#(
   parameter int SHORT_CYCLES = SHORT_SUSPEND_CYCLES,
   parameter int LONG_CYCLES = LONG_SUSPEND_CYCLES
) (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [DATA_W-1:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [DATA_W-1:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic dp_pin,
   input wire logic dm_pin,
   input wire logic [1:0] node_function_state,
   input wire logic nak_summary,
   input wire logic frame_event,
   input wire logic transmit_summary,
   input wire logic fifo_warning_event,
   output logic usb_interrupt,
   output logic event_interrupt,
   output logic wakeup_allowed,
   output logic wakeup_pending
);
   typedef struct packed {
      logic [MAIN_ENABLE_W-1:0] main_event_enable;
      logic [BUS_EVENT_W-1:0] bus_state_event_enable;
      logic [BUS_EVENT_W-1:0] bus_state_events;
      logic [DATA_W-1:0] rd_data;
      logic [BUS_EVENT_W-1:0] rd_clear;
      logic rd_error;
      logic main_irq;
      logic wake_allowed;
      logic wake_pending;
   } core_s;

   core_s st;
   core_s next_st;

   line_event_if line_ev ();

   logic setup_phase;
   logic access_phase;
   logic hit_main;
   logic hit_main_enable;
   logic hit_events;
   logic hit_event_enable;
   logic hit_irq_status;
   logic hit_irq_clear;
   logic hit_irq_enable;
   logic hit_any;
   logic [BUS_EVENT_W-1:0] event_set;
   logic [BUS_EVENT_W-1:0] irq_status;
   logic [BUS_EVENT_W-1:0] irq_enable;
   logic summary;
   logic [MAIN_SOURCE_W-1:0] main_events;
   logic [15:0] main_enable_merged;
   logic [15:0] event_enable_merged;
   logic [15:0] irq_enable_merged;
   node_state_e node_state;

   line_monitor #(
      .SHORT_CYCLES(SHORT_CYCLES),
      .LONG_CYCLES(LONG_CYCLES)
   ) u_line_monitor (
      .ref_clk(ref_clk),
      .reset(reset),
      .dp_pin(dp_pin),
      .dm_pin(dm_pin),
      .ev(line_ev.monitor)
   );

   // address decode
   always_comb begin
      setup_phase = psel & ~penable;
      access_phase = psel & penable;
      hit_main = (paddr == reg_addr(MAIN_EVENT_INDEX));
      hit_main_enable = (paddr == reg_addr(MAIN_EVENT_ENABLE_INDEX));
      hit_events = (paddr == reg_addr(BUS_STATE_EVENTS_INDEX));
      hit_event_enable = (paddr == reg_addr(BUS_STATE_EVENT_ENABLE_INDEX));
      hit_irq_status = (paddr == IRQ_STATUS_ADDR);
      hit_irq_clear = (paddr == IRQ_CLEAR_ADDR);
      hit_irq_enable = (paddr == IRQ_ENABLE_ADDR);
      hit_any = hit_main | hit_main_enable | hit_events | hit_event_enable
                | hit_irq_status | hit_irq_clear | hit_irq_enable;
   end

   // event sources, summary and main event word
   always_comb begin
      node_state = node_state_e'(node_function_state);
      event_set = '0;
      event_set[RESUME_BIT] = (node_state == node_suspend) & line_ev.non_idle;
      event_set[RESET_BIT] = line_ev.se0_reset;
      event_set[LONG_SUSPEND_BIT] = line_ev.long_idle;
      event_set[SHORT_SUSPEND_BIT] = line_ev.short_idle;
      event_set[PACKET_END_BIT] = line_ev.packet_end;
      summary = |(st.bus_state_events & st.bus_state_event_enable);
      main_events = '0;
      main_events[NAK_BIT] = nak_summary;
      main_events[FRAME_BIT] = frame_event;
      main_events[TRANSMIT_BIT] = transmit_summary;
      main_events[SUMMARY_BIT] = summary;
      main_events[WARNING_BIT] = fifo_warning_event;
      main_enable_merged = lane_merge({4'h0, st.main_event_enable}, pwdata[15:0], pstrb[1:0]);
      event_enable_merged = lane_merge({8'h00, st.bus_state_event_enable, 3'h0},
                                       pwdata[15:0], pstrb[1:0]);
      irq_enable_merged = lane_merge({8'h00, irq_enable, 3'h0}, pwdata[15:0], pstrb[1:0]);
   end

   irq_bank u_irq_bank (
      .ref_clk(ref_clk),
      .reset(reset),
      .event_set(event_set & ~st.bus_state_events),
      .clear_we(access_phase & pwrite & hit_irq_clear & pstrb[0]),
      .clear_bits(pwdata[BUS_EVENT_LSB +: BUS_EVENT_W]),
      .enable_we(access_phase & pwrite & hit_irq_enable),
      .enable_bits(irq_enable_merged[BUS_EVENT_LSB +: BUS_EVENT_W]),
      .status(irq_status),
      .enable(irq_enable),
      .irq(event_interrupt)
   );

   always_comb begin
      next_st = st;
      // read data is captured in the setup cycle; the access phase returns it
      if (setup_phase) begin
         next_st.rd_data = '0;
         next_st.rd_clear = '0;
         next_st.rd_error = ~hit_any;
         if (!pwrite) begin
            if (hit_main) begin
               next_st.rd_data[MAIN_SOURCE_W-1:0] = main_events;
            end
            if (hit_main_enable) begin
               next_st.rd_data[MAIN_ENABLE_W-1:0] = st.main_event_enable;
            end
            if (hit_events) begin
               // only the flags returned are cleared, so later events survive
               next_st.rd_data[BUS_EVENT_LSB +: BUS_EVENT_W] = st.bus_state_events;
               next_st.rd_clear = st.bus_state_events;
            end
            if (hit_event_enable) begin
               next_st.rd_data[BUS_EVENT_LSB +: BUS_EVENT_W] = st.bus_state_event_enable;
            end
            if (hit_irq_status) begin
               next_st.rd_data[BUS_EVENT_LSB +: BUS_EVENT_W] = irq_status;
            end
            if (hit_irq_enable) begin
               next_st.rd_data[BUS_EVENT_LSB +: BUS_EVENT_W] = irq_enable;
            end
         end
      end
      // clearing read of the flags; a new event wins over the clear
      if (access_phase && !pwrite && hit_events) begin
         next_st.bus_state_events = st.bus_state_events & ~st.rd_clear;
      end
      next_st.bus_state_events = next_st.bus_state_events | event_set;
      if (access_phase && pwrite) begin
         if (hit_main_enable) begin
            next_st.main_event_enable = main_enable_merged[MAIN_ENABLE_W-1:0];
         end
         if (hit_event_enable) begin
            next_st.bus_state_event_enable =
               event_enable_merged[BUS_EVENT_LSB +: BUS_EVENT_W];
         end
      end
      next_st.main_irq = st.main_event_enable[MASTER_ENABLE_BIT]
                         & |(main_events & st.main_event_enable[MAIN_SOURCE_W-1:0]);
      // remote wake-up bookkeeping
      if (line_ev.long_idle) begin
         next_st.wake_allowed = 1'b1;
      end else if (line_ev.non_idle && !st.wake_pending) begin
         next_st.wake_allowed = 1'b0;
      end
      if (node_state == node_resume && st.wake_allowed) begin
         next_st.wake_pending = 1'b1;
      end else if (line_ev.packet_end) begin
         next_st.wake_pending = 1'b0;
         next_st.wake_allowed = 1'b0;
      end
   end

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         st.main_event_enable <= MAIN_EVENT_ENABLE_RESET;
         st.bus_state_event_enable <= BUS_STATE_ENABLE_RESET;
         st.bus_state_events <= BUS_STATE_EVENTS_RESET;
         st.rd_data <= '0;
         st.rd_clear <= '0;
         st.rd_error <= 1'b0;
         st.main_irq <= 1'b0;
         st.wake_allowed <= 1'b0;
         st.wake_pending <= 1'b0;
      end else begin
         st <= next_st;
      end
   end

   assign prdata = st.rd_data;
   assign pready = access_phase;
   assign pslverr = access_phase & st.rd_error;
   assign usb_interrupt = st.main_irq;
   assign wakeup_allowed = st.wake_allowed;
   assign wakeup_pending = st.wake_pending;
endmodule

/* File: verif/usb_bus_state_properties.sv */
// port assertions for the usb bus state event block
`timescale 1ns/10ps
module usb_bus_state_properties
   import usb_bus_state_pkg::*;
#(
   parameter int SHORT_CYCLES = SHORT_SUSPEND_CYCLES,
   parameter int LONG_CYCLES = LONG_SUSPEND_CYCLES
) (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [DATA_W-1:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic [DATA_W-1:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic dp_pin,
   input wire logic dm_pin,
   input wire logic [1:0] node_function_state,
   input wire logic nak_summary,
   input wire logic usb_interrupt,
   input wire logic event_interrupt,
   input wire logic wakeup_allowed,
   input wire logic wakeup_pending
);
   logic [7:0] mee;
   logic [7:0] idle_cnt;
   wire acc = psel && penable;
   wire mapped = paddr inside {12'h030, 12'h038, 12'h040, 12'h048, 12'h060, 12'h064, 12'h068};
   // shadow of main enable low byte and count of idle line cycles
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         mee <= 8'h00;
         idle_cnt <= 8'h00;
      end else begin
         if (acc && pwrite && paddr == 12'h038 && pstrb[0])
            mee <= pwdata[7:0];
         if (!(dp_pin && !dm_pin))
            idle_cnt <= 8'h00;
         else if (idle_cnt != 8'hFF)
            idle_cnt <= idle_cnt + 8'h01;
      end
   end
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset);
   chk_ready_access: assert property (pready == acc)
      else $error("pready differs from access phase");
   chk_err_access: assert property (pslverr |-> acc)
      else $error("error outside access phase");
   chk_err_unmapped: assert property (acc && !mapped |-> pslverr)
      else $error("unmapped access without error");
   chk_err_mapped: assert property (acc && mapped |-> !pslverr)
      else $error("mapped access with error");
   chk_reserved_zero: assert property (acc && !pwrite && paddr == 12'h040 |->
      prdata[31:8] == 24'h000000 && prdata[2:0] == 3'h0)
      else $error("reserved event bits not zero");
   chk_irq_master: assert property (usb_interrupt |-> $past(mee[7]))
      else $error("interrupt without master enable");
   chk_irq_nak: assert property ($past(mee[7] && mee[4] && nak_summary) |-> usb_interrupt)
      else $error("enabled nak event without interrupt");
   chk_wake_cause: assert property ($rose(wakeup_pending) |->
      $past(wakeup_allowed) && $past(node_function_state) == 2'h1)
      else $error("wake-up pending without cause");
   chk_long_early: assert property ($rose(wakeup_allowed) |-> idle_cnt >= LONG_CYCLES)
      else $error("long idle flagged too early");
   chk_long_due: assert property (idle_cnt == LONG_CYCLES + 8 |-> wakeup_allowed)
      else $error("long idle not flagged");
   cov_wake: cover property ($rose(wakeup_pending));
   cov_usb_irq: cover property ($rose(usb_interrupt));
   cov_event_irq: cover property ($rose(event_interrupt));
endmodule

bind usb_bus_state_events usb_bus_state_properties #(.SHORT_CYCLES(SHORT_CYCLES),
   .LONG_CYCLES(LONG_CYCLES)) i_props (.ref_clk(ref_clk), .reset(reset), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .dp_pin(dp_pin), .dm_pin(dm_pin),
   .node_function_state(node_function_state), .nak_summary(nak_summary),
   .usb_interrupt(usb_interrupt), .event_interrupt(event_interrupt),
   .wakeup_allowed(wakeup_allowed), .wakeup_pending(wakeup_pending));

/* File: verif/usb_host_model.sv */
// upstream host model driving the usb line pins
`timescale 1ns/10ps
module usb_host_model (
   input wire logic [1:0] line_cmd,
   output logic dp_pin,
   output logic dm_pin
);
   // 0 idle j, 1 k, 2 single-ended zero
   always_comb begin
      dp_pin = (line_cmd == 2'h0);
      dm_pin = (line_cmd == 2'h1);
   end
endmodule

/* File: verif/testbench.sv */
// self-checking bench for the usb bus state event logic
`timescale 1ns/10ps
module testbench;
   import usb_bus_state_pkg::*;
   localparam int LONG_N = 60;
   logic ref_clk, reset, psel, penable, pwrite, pready, pslverr, dp_pin, dm_pin, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0] pstrb;
   logic [1:0] node, line_cmd;
   logic [4:0] src;
   logic usb_interrupt, event_interrupt, wakeup_allowed, wakeup_pending;
   int failures, n_tests;
   usb_bus_state_events #(.SHORT_CYCLES(30), .LONG_CYCLES(LONG_N)) i_dut (
      .ref_clk(ref_clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .dp_pin(dp_pin), .dm_pin(dm_pin), .node_function_state(node),
      .nak_summary(src[4]), .frame_event(src[3]), .transmit_summary(src[2]),
      .fifo_warning_event(src[0]), .usb_interrupt(usb_interrupt),
      .event_interrupt(event_interrupt), .wakeup_allowed(wakeup_allowed),
      .wakeup_pending(wakeup_pending));
   usb_host_model i_host (.line_cmd(line_cmd), .dp_pin(dp_pin), .dm_pin(dm_pin));
   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         failures++;
         $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask
   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      @(posedge ref_clk);
      while (pready !== 1'b1) begin
         n++;
         if (n > 20) begin
            failures++;
            finish_test();
         end
         @(posedge ref_clk);
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge ref_clk);
   endtask
   task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      check(rd, exp);
   endtask
   task automatic line(input logic [1:0] c, input int n);
      line_cmd <= c;
      repeat (n) @(posedge ref_clk);
   endtask
   task automatic packet_end();
      line(2'h2, 3);
      line(2'h0, 8);
   endtask
   task automatic t_regs();
      rdc(12'h038, 32'h0);
      rdc(12'h048, 32'h0);
      apb(1'b1, 12'h038, 32'hFFFF);
      rdc(12'h038, 32'h0FFF);
      apb(1'b1, 12'h048, 32'hFFFF);
      rdc(12'h048, 32'hF8);
      apb(1'b1, 12'h038, 32'h0);
      apb(1'b1, 12'h048, 32'h0);
      apb(1'b0, 12'h040, 32'h0);
      apb(1'b1, 12'h040, 32'hFF);
      rdc(12'h040, 32'h0);
      apb(1'b0, 12'h07C, 32'h0);
      check(err, 1'b1);
   endtask
   task automatic t_bus_reset();
      line(2'h2, 60);
      line(2'h0, 10);
      node <= 2'h0;
      rdc(12'h040, 32'h40);
      repeat (30) @(posedge ref_clk);
      rdc(12'h040, 32'h10);
      repeat (25) @(posedge ref_clk);
      rdc(12'h040, 32'h20);
      check(wakeup_allowed, 1'b1);
      rdc(12'h040, 32'h0);
      repeat (2000) @(posedge ref_clk);
      node <= 2'h2;
   endtask
   task automatic t_resume();
      packet_end();
      rdc(12'h040, 32'h08);
      line(2'h1, 4);
      line(2'h0, 8);
      rdc(12'h040, 32'h0);
      node <= 2'h3;
      line(2'h1, 4);
      line(2'h0, 8);
      rdc(12'h040, 32'h80);
      node <= 2'h2;
   endtask
   task automatic t_wake();
      line(2'h0, LONG_N + 12);
      rdc(12'h040, 32'h30);
      check(wakeup_allowed, 1'b1);
      node <= 2'h1;
      repeat (2) @(posedge ref_clk);
      check(wakeup_pending, 1'b1);
      node <= 2'h2;
      line(2'h1, 6);
      check(wakeup_pending, 1'b1);
      packet_end();
      check(wakeup_pending, 1'b0);
      rdc(12'h040, 32'h08);
   endtask
   task automatic t_summary();
      apb(1'b1, 12'h048, 32'h08);
      apb(1'b1, 12'h038, 32'h82);
      packet_end();
      check(usb_interrupt, 1'b1);
      rdc(12'h030, 32'h02);
      rdc(12'h040, 32'h08);
      @(posedge ref_clk);
      check(usb_interrupt, 1'b0);
      rdc(12'h030, 32'h0);
      apb(1'b1, 12'h038, 32'h02);
      packet_end();
      check(usb_interrupt, 1'b0);
      apb(1'b0, 12'h040, 32'h0);
      apb(1'b1, 12'h048, 32'h0);
      apb(1'b1, 12'h038, 32'h82);
      packet_end();
      check(usb_interrupt, 1'b0);
      rdc(12'h040, 32'h08);
      for (int i = 0; i < 5; i++) begin
         if (i != 1) begin
            apb(1'b1, 12'h038, 32'h80 | (32'h1 << i));
            src <= 5'h01 << i;
            repeat (3) @(posedge ref_clk);
            check(usb_interrupt, 1'b1);
            rdc(12'h030, 32'h1 << i);
            apb(1'b1, 12'h038, 32'h1F);
            @(posedge ref_clk);
            check(usb_interrupt, 1'b0);
            src <= 5'h00;
         end
      end
   endtask
   task automatic t_irq();
      // let both idle flags fire, then start from empty flags and status
      line(2'h0, LONG_N + 12);
      apb(1'b0, 12'h040, 32'h0);
      apb(1'b1, 12'h064, 32'hF8);
      apb(1'b1, 12'h068, 32'h08);
      check(event_interrupt, 1'b0);
      packet_end();
      check(event_interrupt, 1'b1);
      rdc(12'h060, 32'h08);
      apb(1'b1, 12'h064, 32'h08);
      check(event_interrupt, 1'b0);
      rdc(12'h060, 32'h0);
      rdc(12'h040, 32'h08);
   endtask
   initial begin
      reset = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      pstrb = 4'h3;
      node = 2'h2;
      line_cmd = 2'h0;
      src = 5'h00;
      failures = 0;
      n_tests = 0;
      repeat (12) @(posedge ref_clk);
      reset <= 1'b0;
      repeat (LONG_N + 20) @(posedge ref_clk);
      t_regs();
      t_bus_reset();
      t_resume();
      t_wake();
      t_summary();
      t_irq();
      finish_test();
   end
endmodule
